/* File: sxr_core.sv */
// Operation
// - Option mismatch answers invalid-accel once, records no fault.
// - Option mismatch skips arming update, pulse-code output untouched.
// - Bad write or read address answers invalid-register, access skipped.
// - Config lock rejects every write except the device control register.
// - Init flag set gives internal-error-present to accel requests; reset flag gives invalid-accel.
// - Init flag clears when init finishes; reset flag clears on status read.
// - Init or reset flag blocks arming updates, disables pulse-code output.
// - OTP CRC, register CRC, self-test or bad logic state set internal error.
// - CRC internal error answers internal-error-present, no arming update.
// - Register CRC error after lock clears only by reset, not status read.
// - OTP shadow CRC error is permanent.
// - Self-test internal error answers self-test-error, no arming update.
// - Self-test error holds until status read; stays set if still failing.
// - Over-range gives valid accel answer, status 10, arming updated.
// - Status 10 persists one more transfer after over-range ends.
// - Offset and modulator over-range flags latch until status read.
// - First response after any reset is the SPI error response.
// - After reset and init, accel requests get invalid-accel until status read.
// - Register accesses proceed despite accel, CRC, self-test, range errors.
// - Ten-bit data linear -480..480 signed, 32..992 unsigned, offset 512.
// - Fixed priority framing, verify, invalid, init, reset, CRC, test, range.
module sxr_core (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Frame select pin, active low
  input wire logic CS_N,
  // Decoded command of the frame just ending
  input wire sxr_pkg::sxr_cmd_t CMD,
  // Configuration and internal sources
  input wire sxr_pkg::sxr_cfg_t CFG,
  input wire sxr_pkg::sxr_fault_t FAULT,
  input wire logic INIT_DONE,
  input wire logic OFS_OVR_X,
  input wire logic OFS_OVR_Y,
  input wire logic MOD_OVR,
  input wire logic signed [sxr_pkg::DV_W:0] ACCEL_X,
  input wire logic signed [sxr_pkg::DV_W:0] ACCEL_Y,
  // Response for the next transfer
  output sxr_pkg::sxr_resp_t RESP,
  output logic RESP_VALID,
  // Side effects
  output logic ARM_UPDATE,
  output logic PCM_DISABLE,
  output logic REG_WRITE,
  output logic REG_READ,
  // Status register view
  output sxr_pkg::sxr_stat_t STATUS
);
  import sxr_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic in_mask(input logic [31:0] mask,
                                   input logic [4:0] a);
    in_mask = mask[a];
  endfunction

  // ****************************************
  // Frame end detection
  // ****************************************
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;

  // Pin is asynchronous; only the second stage feeds the edge finder
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= CS_N;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  wire logic frame_end;
  assign frame_end = cs_sync & ~cs_prev;

  // ****************************************
  // Request classification
  // ****************************************
  wire logic link_ok;
  wire logic mismatch;
  wire logic wr_denied;
  wire logic reg_bad;
  wire logic read_ok;
  wire logic stat_clear;

  assign link_ok = ~CMD.spi_err & ~CMD.miso_err;
  // Arm bit matches either arming config bit being set
  assign mismatch = CMD.is_accel &
                    ((CMD.sd != CFG.sd) | (CMD.arm != (|CFG.arm_cfg)));
  // Lock blocks every write but the control register
  assign wr_denied = ~in_mask(WR_MASK, CMD.addr) |
                     (CFG.config_lock_bit & (CMD.addr != CTRL_ADDR));
  assign reg_bad = ~CMD.is_accel &
                   (CMD.is_write ? wr_denied :
                    ~in_mask(RD_MASK, CMD.addr));
  assign read_ok = ~CMD.is_accel & ~CMD.is_write & link_ok & ~reg_bad;
  // A good status read clears the read-sensitive flags
  assign stat_clear = frame_end & read_ok & (CMD.addr == STAT_ADDR);

  // ****************************************
  // Internal error sources
  // ****************************************
  logic crc_otp;
  logic crc_wreg;
  logic crc_locked;
  logic st_err;
  logic bad_state;
  wire logic next_crc_wreg;
  wire logic next_st_err;
  wire logic next_bad_state;

  // Source input wins over a clear in the same cycle
  assign next_crc_wreg = FAULT.wreg_crc |
                         (crc_wreg & ~(stat_clear & ~crc_locked));
  assign next_st_err = FAULT.selftest | (st_err & ~stat_clear);
  assign next_bad_state = FAULT.bad_state | (bad_state & ~stat_clear);

  // Sticky error sources, only a device reset wipes them all
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      crc_otp <= 1'b0;
      crc_wreg <= 1'b0;
      crc_locked <= 1'b0;
      st_err <= 1'b0;
      bad_state <= 1'b0;
    end else begin
      crc_otp <= crc_otp | FAULT.otp_crc;
      crc_wreg <= next_crc_wreg;
      crc_locked <= crc_locked |
                    (FAULT.wreg_crc & CFG.config_lock_bit);
      st_err <= next_st_err;
      bad_state <= next_bad_state;
    end
  end

  wire logic crc_err;
  wire logic int_err;
  assign crc_err = crc_otp | crc_wreg;
  assign int_err = crc_err | st_err | bad_state;

  // ****************************************
  // Reset indications and over-range latches
  // ****************************************
  logic init_flag;
  logic rst_flag;
  logic ofs_x_lat;
  logic ofs_y_lat;
  logic mod_lat;

  // Both reset indications start set out of reset
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      init_flag <= 1'b1;
      rst_flag <= 1'b1;
      ofs_x_lat <= 1'b0;
      ofs_y_lat <= 1'b0;
      mod_lat <= 1'b0;
    end else begin
      init_flag <= init_flag & ~INIT_DONE;
      rst_flag <= rst_flag & ~stat_clear;
      ofs_x_lat <= OFS_OVR_X | (ofs_x_lat & ~stat_clear);
      ofs_y_lat <= OFS_OVR_Y | (ofs_y_lat & ~stat_clear);
      mod_lat <= MOD_OVR | (mod_lat & ~stat_clear);
    end
  end

  // ****************************************
  // Over-range trailing status
  // ****************************************
  logic was_x;
  logic was_y;
  wire logic ovr_x;
  wire logic ovr_y;
  wire logic ovr_now;
  wire logic ovr_seen;
  wire logic x_xfer;
  wire logic y_xfer;

  assign ovr_x = OFS_OVR_X | MOD_OVR;
  assign ovr_y = OFS_OVR_Y | MOD_OVR;
  assign ovr_now = CMD.axis ? ovr_y : ovr_x;
  assign ovr_seen = ovr_now | (CMD.axis ? was_y : was_x);
  assign x_xfer = frame_end & CMD.is_accel & ~CMD.axis;
  assign y_xfer = frame_end & CMD.is_accel & CMD.axis;

  // Memory of a past over-range is spent by one transfer on that axis
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      was_x <= 1'b0;
      was_y <= 1'b0;
    end else begin
      was_x <= ovr_x | (was_x & ~x_xfer);
      was_y <= ovr_y | (was_y & ~y_xfer);
    end
  end

  // ****************************************
  // Response selection
  // ****************************************
  wire sxr_code_t next_code;
  wire logic [1:0] next_status;
  wire logic [DV_W-1:0] dv_code;
  wire logic accel_ok;

  // Priority chain; register accesses bypass the accel-only causes
  assign next_code =
    CMD.spi_err ? RSP_SPI_ERR :
    CMD.miso_err ? RSP_MISO_ERR :
    reg_bad ? RSP_INV_REG :
    ~CMD.is_accel ? (CMD.is_write ? RSP_REG_WR : RSP_REG_RD) :
    mismatch ? RSP_INV_ACCEL :
    init_flag ? RSP_INT_ERR :
    rst_flag ? RSP_INV_ACCEL :
    crc_err ? RSP_INT_ERR :
    st_err ? RSP_ST_ERR :
    bad_state ? RSP_INT_ERR : RSP_ACCEL;
  assign accel_ok = CMD.is_accel & (next_code == RSP_ACCEL);
  assign next_status = (accel_ok & ovr_seen) ? ST_OVR : ST_NORMAL;

  // Data path formatting, shared by both axes
  sxr_dv_fmt #(.W(DV_W)) i_sxr_dv_fmt (
    .raw(CMD.axis ? ACCEL_Y : ACCEL_X),
    .signed_mode(CFG.sd),
    .fault(int_err),
    .code(dv_code)
  );

  // ****************************************
  // Output registers
  // ****************************************
  // Reset value makes the first answer a framing error
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RESP <= '{code: RSP_SPI_ERR, status: ST_NORMAL,
                digital_output_value: '0};
    end else if (frame_end) begin
      RESP <= '{code: next_code, status: next_status,
                digital_output_value: accel_ok ? dv_code : '0};
    end
  end

  // Strobes last one cycle after the frame closes
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RESP_VALID <= 1'b0;
      ARM_UPDATE <= 1'b0;
      REG_WRITE <= 1'b0;
      REG_READ <= 1'b0;
    end else begin
      RESP_VALID <= frame_end;
      ARM_UPDATE <= frame_end & accel_ok;
      // A verify error does not stop a write from landing
      REG_WRITE <= frame_end & ~CMD.is_accel & CMD.is_write &
                   ~CMD.spi_err & ~reg_bad;
      REG_READ <= frame_end & read_ok;
    end
  end

  // Status view and pulse-code gate follow the flags
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STATUS <= '{init_in_progress_flag: 1'b1, reset_occurred_flag: 1'b1,
                  default: 1'b0};
      PCM_DISABLE <= 1'b1;
    end else begin
      STATUS <= '{init_in_progress_flag: init_flag,
                  reset_occurred_flag: rst_flag,
                  internal_error_flag: int_err,
                  offset_ovr_x: ofs_x_lat,
                  offset_ovr_y: ofs_y_lat,
                  modulator_overrange_flag: mod_lat};
      PCM_DISABLE <= init_flag | rst_flag;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic seen;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seen <= 1'b0;
    end else begin
      seen <= seen | RESP_VALID;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_first_resp: assert property (
    !seen && !RESP_VALID |-> RESP.code == RSP_SPI_ERR)
    else $error("first response not framing error");
  chk_mismatch_resp: assert property (
    frame_end && link_ok && mismatch |=>
      RESP.code == RSP_INV_ACCEL && !ARM_UPDATE
      ##1 !(RESP_VALID && RESP.code == RSP_INV_ACCEL && !$past(mismatch, 2)
            && !$past(rst_flag, 2)))
    else $error("mismatch answer wrong");
  chk_lock_write: assert property (
    frame_end && link_ok && !CMD.is_accel && CMD.is_write &&
    CFG.config_lock_bit && CMD.addr != CTRL_ADDR |=>
      RESP.code == RSP_INV_REG && !REG_WRITE)
    else $error("locked write not refused");
  chk_init_resp: assert property (
    frame_end && link_ok && CMD.is_accel && !mismatch && init_flag |=>
      RESP.code == RSP_INT_ERR && !ARM_UPDATE && PCM_DISABLE)
    else $error("init flag answer wrong");
  chk_stat_clear: assert property (
    stat_clear && !init_flag |=> !rst_flag ##1 !PCM_DISABLE)
    else $error("status read did not clear reset flag");
  chk_otp_perm: assert property (
    crc_otp |=> crc_otp && STATUS.internal_error_flag)
    else $error("otp crc error cleared");
  chk_locked_crc: assert property (
    crc_locked |-> ##[1:2] STATUS.internal_error_flag)
    else $error("locked crc error cleared");
  chk_selftest_hold: assert property (
    st_err && !stat_clear |=> st_err)
    else $error("self-test error dropped early");
  chk_ovr_status: assert property (
    frame_end && accel_ok && $past(ovr_now) |=>
      RESP.status == ST_OVR && ARM_UPDATE)
    else $error("over-range status missing");
  chk_ovr_latch: assert property (
    ofs_x_lat && !stat_clear |=> ofs_x_lat ##1 STATUS.offset_ovr_x)
    else $error("offset over-range latch lost");
  chk_reg_exec: assert property (
    frame_end && !CMD.is_accel && CMD.is_write && !CMD.spi_err &&
    !reg_bad |=> REG_WRITE && RESP.code != RSP_INV_REG)
    else $error("register write blocked");

  cov_accel_ok: cover property (frame_end && accel_ok);
  cov_ovr_tail: cover property (frame_end && accel_ok && !ovr_now && ovr_seen);
  cov_lock_refuse: cover property (frame_end && reg_bad && CMD.is_write);
  cov_stat_read: cover property (stat_clear && rst_flag);

endmodule

/* File: sxr_pkg.sv */
package sxr_pkg;

  // ****************************************
  // Register map of the command port
  // ****************************************
  localparam logic [4:0] CTRL_ADDR = 5'h0a;
  localparam logic [4:0] STAT_ADDR = 5'h0b;
  // One bit per address, bit n set when address n may be written or read
  localparam logic [31:0] WR_MASK = 32'h0000_07f0;
  localparam logic [31:0] RD_MASK = 32'h0000_0fff;

  // ****************************************
  // Response status and data codes
  // ****************************************
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_OVR = 2'h2;
  localparam int DV_W = 10;
  localparam logic signed [DV_W:0] DV_LIN_MAX = 11'sh1e0;
  localparam logic signed [DV_W:0] DV_LIN_MIN = 11'sh620;
  localparam logic [DV_W-1:0] DV_UNS_OFFSET = 10'h200;
  localparam logic [DV_W-1:0] DV_FAULT_UNS = 10'h000;
  localparam logic [DV_W-1:0] DV_FAULT_SGN = 10'h200;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    RSP_SPI_ERR,
    RSP_MISO_ERR,
    RSP_INV_ACCEL,
    RSP_INV_REG,
    RSP_INT_ERR,
    RSP_ST_ERR,
    RSP_ACCEL,
    RSP_REG_WR,
    RSP_REG_RD
  } sxr_code_t;

  typedef struct packed {
    logic is_accel;
    logic axis;
    logic sd;
    logic arm;
    logic is_write;
    logic [4:0] addr;
    logic spi_err;
    logic miso_err;
  } sxr_cmd_t;

  typedef struct packed {
    logic [1:0] arm_cfg;
    logic sd;
    logic config_lock_bit;
  } sxr_cfg_t;

  typedef struct packed {
    logic otp_crc;
    logic wreg_crc;
    logic selftest;
    logic bad_state;
  } sxr_fault_t;

  typedef struct packed {
    logic init_in_progress_flag;
    logic reset_occurred_flag;
    logic internal_error_flag;
    logic offset_ovr_x;
    logic offset_ovr_y;
    logic modulator_overrange_flag;
  } sxr_stat_t;

  typedef struct packed {
    sxr_code_t code;
    logic [1:0] status;
    logic [DV_W-1:0] digital_output_value;
  } sxr_resp_t;

endpackage

/* File: sxr_dv_fmt.sv */
module sxr_dv_fmt #(
  parameter int W = sxr_pkg::DV_W
) (
  // Raw axis value, one bit wider than the output
  input wire logic signed [W:0] raw,
  // Format select and fault marker
  input wire logic signed_mode,
  input wire logic fault,
  // Ten bit output code
  output logic [W-1:0] code
);
  import sxr_pkg::*;

  // ****************************************
  // Clamp to the linear range
  // ****************************************
  wire logic signed [W:0] clamped;
  wire logic [W-1:0] sgn_code;
  wire logic [W-1:0] uns_code;

  // Readings past the linear range are never produced; only the fault codes lie outside it
  assign clamped = (raw > DV_LIN_MAX) ? DV_LIN_MAX :
                   (raw < DV_LIN_MIN) ? DV_LIN_MIN : raw;
  assign sgn_code = clamped[W-1:0];
  // Zero acceleration sits at mid scale in unsigned form
  assign uns_code = sgn_code + DV_UNS_OFFSET;

  // ****************************************
  // Fault code selection
  // ****************************************
  // Lowest code only ever means a fault, never a reading
  assign code = fault ? (signed_mode ? DV_FAULT_SGN : DV_FAULT_UNS) :
                (signed_mode ? sgn_code : uns_code);

endmodule

/* File: sxr_host_model.sv */
module sxr_host_model import sxr_pkg::*; (
  // Device clock
  input wire logic CLK,
  // Link pins toward the block
  output logic CS_N,
  output sxr_pkg::sxr_cmd_t CMD,
  // Answer side of the block
  input wire sxr_pkg::sxr_resp_t RESP,
  input wire logic RESP_VALID,
  input wire logic ARM_UPDATE,
  input wire logic REG_WRITE,
  input wire logic REG_READ
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Host side of one transfer
  // ****************************************
  // Frame spans two link periods of 320 ns
  localparam int FRAME_NS = 640;

  // Idle: not selected, command lines parked
  initial begin
    CS_N = 1'b1;
    CMD = '0;
  end

  // One frame, then wait bounded for the answer pulse
  task automatic xfer(input sxr_cmd_t c, output sxr_resp_t r,
                      output logic [2:0] fx, output bit ok);
    int n;
    ok = 1'b0;
    r = '0;
    fx = '0;
    @(negedge CLK);
    CMD = c;
    CS_N = 1'b0;
    #(FRAME_NS);
    CS_N = 1'b1;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge CLK);
      if (RESP_VALID === 1'b1) begin
        ok = 1'b1;
        r = RESP;
        fx = {ARM_UPDATE, REG_WRITE, REG_READ};
      end
    end
    // Released lines must not keep the old command
    CMD = ~c;
    // Idle gap of three clocks before the next frame
    repeat (3) @(negedge CLK);
  endtask
endmodule

/* File: sxr_core_bench.sv */
module sxr_core_bench import sxr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam logic [4:0] ADRS [6] = '{5'h00, 5'h04, 5'h0a, 5'h0b,
                                      5'h0c, 5'h1f};
  logic clk = 1'b0;
  logic sys_rst, cs_n, init_done, ovr_x, ovr_y, mod_ovr;
  logic resp_valid, arm_update, pcm_disable, reg_write, reg_read;
  logic signed [DV_W:0] ax, ay;
  sxr_cmd_t cmd, c;
  sxr_cfg_t cfg;
  sxr_fault_t fault;
  sxr_resp_t resp;
  sxr_stat_t status;
  logic inv;
  int num_errors = 0;
  int n_checks = 0;

  // Device clock, 25 MHz
  always #20 clk = ~clk;

  sxr_core i_sxr_core (.CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n),
    .CMD(cmd), .CFG(cfg), .FAULT(fault), .INIT_DONE(init_done),
    .OFS_OVR_X(ovr_x), .OFS_OVR_Y(ovr_y), .MOD_OVR(mod_ovr),
    .ACCEL_X(ax), .ACCEL_Y(ay), .RESP(resp), .RESP_VALID(resp_valid),
    .ARM_UPDATE(arm_update), .PCM_DISABLE(pcm_disable),
    .REG_WRITE(reg_write), .REG_READ(reg_read), .STATUS(status));

  sxr_host_model i_sxr_host_model (.CLK(clk), .CS_N(cs_n), .CMD(cmd),
    .RESP(resp), .RESP_VALID(resp_valid), .ARM_UPDATE(arm_update),
    .REG_WRITE(reg_write), .REG_READ(reg_read));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Side effects packed as {arm, write, read}
  task automatic req(input sxr_cmd_t q, input sxr_code_t code,
                     input logic [1:0] st, input logic [9:0] dv,
                     input logic [2:0] fx);
    sxr_resp_t r;
    logic [2:0] f;
    bit ok;
    i_sxr_host_model.xfer(q, r, f, ok);
    if (!ok) begin
      num_errors++;
      $display("mismatch answer pulse expected 1 seen 0");
      summarize();
    end
    cmp("response", sxr_resp_t'{code, st, dv}, r);
    cmp("side effects", {13'h0, fx}, {13'h0, f});
  endtask

  function automatic sxr_cmd_t acc(input logic y, input logic sd,
                                   input logic arm);
    acc = '0;
    acc.is_accel = 1'b1;
    acc.axis = y;
    acc.sd = sd;
    acc.arm = arm;
  endfunction

  function automatic sxr_cmd_t rg(input logic wr, input logic [4:0] a);
    rg = '0;
    rg.is_write = wr;
    rg.addr = a;
  endfunction

  // Faults are pulsed; the flag must latch on its own
  task automatic fault_pulse(input sxr_fault_t f);
    fault = f;
    repeat (2) @(negedge clk);
    fault = '0;
    repeat (2) @(negedge clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    cfg = '{2'b01, 1'b0, 1'b0};
    fault = '0;
    init_done = 1'b0;
    {ovr_x, ovr_y, mod_ovr} = 3'b000;
    ax = 11'sd480;
    ay = -11'sd480;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    cmp("flags", 16'h30, {10'h0, status});
    cmp("pcm off", 16'h1, {15'h0, pcm_disable});
    cmp("first answer", {RSP_SPI_ERR, 12'h0}, resp);
    req(acc(0, 0, 1), RSP_INT_ERR, ST_NORMAL, 10'h0, 3'b000);
    init_done = 1'b1;
    repeat (4) @(negedge clk);
    cmp("init flag", 16'h0, {15'h0, status[5]});
    req(acc(0, 0, 1), RSP_INV_ACCEL, ST_NORMAL, 10'h0, 3'b000);
    cmp("pcm off", 16'h1, {15'h0, pcm_disable});
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    cmp("flags", 16'h0, {10'h0, status});
    cmp("pcm off", 16'h0, {15'h0, pcm_disable});
    // Linear range top end in unsigned, bottom end in signed
    req(acc(0, 0, 1), RSP_ACCEL, ST_NORMAL, 10'h3e0, 3'b100);
    cfg.sd = 1'b1;
    req(acc(1, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h220, 3'b100);
    // Option mismatch answers once, records nothing
    req(acc(1, 0, 1), RSP_INV_ACCEL, ST_NORMAL, 10'h0, 3'b000);
    req(acc(1, 1, 0), RSP_INV_ACCEL, ST_NORMAL, 10'h0, 3'b000);
    cmp("internal error", 16'h0, {15'h0, status[3]});
    cmp("pcm off", 16'h0, {15'h0, pcm_disable});
    req(acc(1, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h220, 3'b100);
    c = acc(0, 1, 1);
    c.spi_err = 1'b1;
    req(c, RSP_SPI_ERR, ST_NORMAL, 10'h0, 3'b000);
    c.spi_err = 1'b0;
    c.miso_err = 1'b1;
    req(c, RSP_MISO_ERR, ST_NORMAL, 10'h0, 3'b000);
    // A verify error still lets a register write land
    c = rg(1, 5'h04);
    c.miso_err = 1'b1;
    req(c, RSP_MISO_ERR, ST_NORMAL, 10'h0, 3'b010);
    // Access table, unlocked then locked
    for (int lk = 0; lk < 2; lk++) begin
      cfg.config_lock_bit = lk[0];
      for (int i = 0; i < 12; i++) begin
        inv = i[0] ? (!WR_MASK[ADRS[i/2]] ||
                      (lk[0] && ADRS[i/2] != CTRL_ADDR))
                   : !RD_MASK[ADRS[i/2]];
        req(rg(i[0], ADRS[i/2]), inv ? RSP_INV_REG
            : (i[0] ? RSP_REG_WR : RSP_REG_RD), ST_NORMAL, 10'h0,
            inv ? 3'b000 : (i[0] ? 3'b010 : 3'b001));
      end
    end
    // Offset and modulator over-range
    for (int k = 0; k < 2; k++) begin
      {ovr_x, mod_ovr} = k[0] ? 2'b01 : 2'b10;
      req(acc(0, 1, 1), RSP_ACCEL, ST_OVR, 10'h1e0, 3'b100);
      req(rg(0, CTRL_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
      {ovr_x, mod_ovr} = 2'b00;
      req(acc(0, 1, 1), RSP_ACCEL, ST_OVR, 10'h1e0, 3'b100);
      req(acc(0, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h1e0, 3'b100);
      cmp("range latch", k[0] ? 16'h1 : 16'h4, {13'h0, status[2:0]});
      req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
      cmp("range latch", 16'h0, {13'h0, status[2:0]});
    end
    // Offset over-range on Y leaves X answers alone
    ovr_y = 1'b1;
    req(acc(0, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h1e0, 3'b100);
    req(acc(1, 1, 1), RSP_ACCEL, ST_OVR, 10'h220, 3'b100);
    ovr_y = 1'b0;
    req(acc(1, 1, 1), RSP_ACCEL, ST_OVR, 10'h220, 3'b100);
    req(acc(1, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h220, 3'b100);
    cmp("range latch", 16'h2, {13'h0, status[2:0]});
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    cmp("range latch", 16'h0, {13'h0, status[2:0]});
    // Self-test then bad state, both removed before the read
    for (int k = 0; k < 2; k++) begin
      fault_pulse(k[0] ? 4'b0001 : 4'b0010);
      cmp("internal error", 16'h1, {15'h0, status[3]});
      req(acc(0, 1, 1), k[0] ? RSP_INT_ERR : RSP_ST_ERR, ST_NORMAL,
          10'h0, 3'b000);
      cmp("pcm off", 16'h0, {15'h0, pcm_disable});
      req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
      req(acc(0, 1, 1), RSP_ACCEL, ST_NORMAL, 10'h1e0, 3'b100);
    end
    // Self-test failure still present at the read
    fault = 4'b0010;
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    cmp("internal error", 16'h1, {15'h0, status[3]});
    fault = '0;
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    cmp("internal error", 16'h0, {15'h0, status[3]});
    // Register CRC while locked survives the read
    fault_pulse(4'b0100);
    req(acc(0, 1, 1), RSP_INT_ERR, ST_NORMAL, 10'h0, 3'b000);
    cmp("pcm off", 16'h0, {15'h0, pcm_disable});
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    req(acc(0, 1, 1), RSP_INT_ERR, ST_NORMAL, 10'h0, 3'b000);
    // Mid-run reset clears it
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    cmp("flags", 16'h2, {14'h0, status[4:3]});
    cmp("first answer", {RSP_SPI_ERR, 12'h0}, resp);
    fault_pulse(4'b0010);
    req(acc(0, 1, 1), RSP_INV_ACCEL, ST_NORMAL, 10'h0, 3'b000);
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    // Shadow array CRC never clears
    fault_pulse(4'b1000);
    req(rg(0, STAT_ADDR), RSP_REG_RD, ST_NORMAL, 10'h0, 3'b001);
    cmp("internal error", 16'h1, {15'h0, status[3]});
    req(acc(0, 1, 1), RSP_INT_ERR, ST_NORMAL, 10'h0, 3'b000);
    summarize();
  end
endmodule
